/* File: verilog/mcc_pkg.sv */
// Constants, field layout, states and carriers of the multiplex chaining
// and write sequencer. Assumes a 64-bit control word, bit 0 is the MSB.
package mcc_pkg;
	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [11:0] MCC_CTRL_OFS = 12'h000;
	localparam logic [11:0] MCC_STAT_OFS = 12'h004;
	localparam logic [11:0] MCC_BYTES_OFS = 12'h008;
	localparam int MCC_CTRL_EN_BIT = 0;
	localparam int MCC_CTRL_ERRCLR_BIT = 1;
	localparam logic MCC_CTRL_EN_RST = 1'b0;
	// ----------------------------------------------------------------
	// Control word fields (vector index = 63 - printed bit)
	// ----------------------------------------------------------------
	localparam int MCC_OP_LSB = 56;
	localparam int MCC_ADR_LSB = 32;
	localparam int MCC_ADR_W = 24;
	localparam int MCC_DAB_LSB = 32;
	localparam int MCC_CD_BIT = 31;
	localparam int MCC_CC_BIT = 30;
	localparam int MCC_SLI_BIT = 29;
	localparam int MCC_PCI_BIT = 27;
	localparam int MCC_PF_BIT = 24;
	localparam int MCC_DCHK_BIT = 19;
	localparam int MCC_BC_LSB = 16;
	localparam int MCC_CNT_LSB = 0;
	localparam int MCC_CNT_W = 16;
	localparam int MCC_RES_LSB = 0;
	localparam logic [23:0] MCC_ADR_STEP = 24'h00_0008;
	localparam logic [15:0] MCC_CNT_CHAIN_LIM = 16'h0008;
	localparam logic [2:0] MCC_BC_FULL = 3'h7;
	// Low two bits of the operation code
	localparam logic [1:0] MCC_OP_RBWD = 2'h0;
	localparam logic [1:0] MCC_OP_READ = 2'h2;
	// Word numbers in local storage
	localparam logic [1:0] MCC_W0 = 2'h0;
	localparam logic [1:0] MCC_W1 = 2'h1;
	localparam logic [1:0] MCC_W2 = 2'h2;
	localparam logic [1:0] MCC_W3 = 2'h3;
	// ----------------------------------------------------------------
	// Sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		MCC_S_IDLE = 4'h0,
		MCC_S_ARB = 4'h1,
		MCC_S_LD0 = 4'h2,
		MCC_S_LD1 = 4'h3,
		MCC_S_EVAL = 4'h4,
		MCC_S_DFETCH = 4'h5,
		MCC_S_XFER = 4'h6,
		MCC_S_DSTORE = 4'h7,
		MCC_S_ST1 = 4'h8,
		MCC_S_ST0 = 4'h9,
		MCC_S_C_LD2 = 4'hA,
		MCC_S_C_ST1 = 4'hB,
		MCC_S_C_ST2 = 4'hC,
		MCC_S_C_WAIT = 4'hD,
		MCC_S_C_STN = 4'hE,
		MCC_S_END = 4'hF
	} mcc_state_t;
	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic we;
		logic [23:0] addr;
		logic [63:0] data;
	} mcc_msreq_t;
	typedef struct packed {
		logic we;
		logic [9:0] addr;
		logic [63:0] data;
	} mcc_lsreq_t;
endpackage

/* File: verilog/mcc_seq.sv */
// Multiplex subchannel main-channel sequencer: write/control byte cycles,
// read byte cycles and data-chained command word fetch and rebuild.
// Assumes one storage bus controller port, one local storage port with a
// one-cycle ack, channel pins asynchronous, and an APB master.
// Operation
// - Chain fetch puts command address on storage
// - Residual gets old address; address plus eight
// - Leftover data word stored as word one
// - After update: rebuild, store word, clock off
// - Keep old opcode, interrupt and check bits
// - Clock back on only after clean cycle
// - Offset true for read, complement backward
// - Ending latch when word zero fetch drops
// - At count one, chain flag decides chaining
// - No stop sent at chain boundary (code still stops a chained write at count zero)
// - Control commands run exactly like writes
// - Write/control evaluate chain, length, interrupt flags (code evaluates only the chain and prefetch flags)
// - Write data fetched at ascending addresses
// - Service in requests cycle, loads both words
// - Zero count: stop, store words, terminate
// - Stop response always ends the operation
// - Byte count seven fetches a new doubleword
// - Each byte: count down, byte count up
// - Address written back only on storage transfer
// - Byte on bus out, then service out
// - Store data and word zero, then end
// - Chained write below eight prefetches word three
// - Chain flag is word zero bit 32
// - Prefetch flag is word zero bit 39
//
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module mcc_seq
	import mcc_pkg::*;
#(
	parameter int UA_W = 8
) (
	input wire logic pclk, // 250 MHz clock
	input wire logic presetn, // Async reset, low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB write
	input wire logic [11:0] paddr, // APB address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire logic op_in, // Operational in pin
	input wire logic svc_in, // Service in pin
	input wire logic [7:0] bus_in, // Bus in pin
	output logic [7:0] bus_out, // Bus out pin
	output logic svc_out, // Service out pin
	output logic cmd_out, // Command out pin
	input wire logic [UA_W-1:0] unit_addr, // Selected unit address
	output logic mch_req, // Main channel priority request
	input wire logic mch_gnt, // Priority granted
	output logic mclk_run, // Main channel clock running
	output logic end_pulse, // Ending latch, one cycle
	output logic ms_req, // Storage bus controller request
	output mcc_msreq_t ms_cmd, // Storage request contents
	input wire logic ms_ack, // Storage cycle over
	input wire logic ms_chk, // Storage check with ack
	input wire logic [63:0] ms_rdata, // Storage data out bus
	output logic ls_req, // Local storage request
	output mcc_lsreq_t ls_cmd, // Local storage request contents
	input wire logic ls_ack, // Local storage done
	input wire logic [63:0] ls_rdata // Local storage read data
);
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] get_byte(input logic [63:0] w,
		input logic [2:0] i);
		return w[{~i, 3'b000} +: 8];
	endfunction

	function automatic logic [63:0] put_byte(input logic [63:0] w,
		input logic [2:0] i, input logic [7:0] b);
		logic [63:0] r;
		r = w;
		r[{~i, 3'b000} +: 8] = b;
		return r;
	endfunction

	mcc_state_t state_q;
	logic [63:0] ctl_q, data_q;
	logic [1:0] op_sync_q, svc_sync_q;
	logic [7:0] bus_s1_q, bus_s2_q;
	logic op_s, svc_s, svc_taken_q;
	logic en_q, err_q, mclk_q, dstore_q, chain_q, pf_need_q, chain_wr_q;
	logic [3:0] keep_q;
	logic ms_req_q, ms_got_q, ms_chk_q;
	logic [63:0] ms_data_q;
	logic ls_req_q, ls_done, ls_need, ms_go, ms_take;
	mcc_lsreq_t ls_next, ls_cmd_q;
	mcc_msreq_t ms_next, ms_cmd_q;
	logic [31:0] bytes_q;
	logic [15:0] cnt;
	logic [2:0] bc, dab, dab_fix;
	logic [23:0] adr;
	logic wr, bwd, cd, err_set;

	assign cnt = ctl_q[MCC_CNT_LSB +: MCC_CNT_W];
	assign bc = ctl_q[MCC_BC_LSB +: 3];
	assign adr = ctl_q[MCC_ADR_LSB +: MCC_ADR_W];
	assign wr = ctl_q[MCC_OP_LSB];
	assign bwd = (ctl_q[MCC_OP_LSB +: 2] == MCC_OP_RBWD);
	assign cd = ctl_q[MCC_CD_BIT];
	assign dab = ms_data_q[MCC_DAB_LSB +: 3];
	assign dab_fix = (keep_q[3:2] == MCC_OP_RBWD) ? ~dab : dab;
	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_sync_q <= 2'h0;
			svc_sync_q <= 2'h0;
			bus_s1_q <= 8'h00;
			bus_s2_q <= 8'h00;
		end else begin
			op_sync_q <= {op_sync_q[0], op_in};
			svc_sync_q <= {svc_sync_q[0], svc_in};
			bus_s1_q <= bus_in;
			bus_s2_q <= bus_s1_q;
		end
	end
	assign op_s = op_sync_q[1];
	assign svc_s = svc_sync_q[1];
	// ----------------------------------------------------------------
	// Local storage port
	// ----------------------------------------------------------------
	always_comb begin
		ls_need = 1'b1;
		ls_next = '{we: 1'b0, addr: {unit_addr, MCC_W0}, data: ctl_q};
		unique case (state_q)
			MCC_S_LD0: ls_next.addr = {unit_addr, MCC_W0};
			MCC_S_LD1: ls_next.addr = {unit_addr, MCC_W1};
			MCC_S_C_LD2: ls_next.addr = {unit_addr, MCC_W2};
			MCC_S_ST1, MCC_S_C_ST1: begin
				ls_next = '{we: 1'b1, addr: {unit_addr, MCC_W1}, data: data_q};
			end
			MCC_S_ST0: ls_next = '{we: 1'b1, addr: {unit_addr, MCC_W0}, data: ctl_q};
			MCC_S_C_ST2: ls_next = '{we: 1'b1, addr: {unit_addr, MCC_W2}, data: ctl_q};
			MCC_S_C_STN: begin
				ls_next.we = 1'b1;
				ls_next.addr = {unit_addr, chain_wr_q ? MCC_W3 : MCC_W0};
			end
			default: ls_need = 1'b0;
		endcase
	end
	assign ls_done = ls_req_q & ls_ack;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ls_req_q <= 1'b0;
			ls_cmd_q <= '0;
		end else if (ls_done) begin
			ls_req_q <= 1'b0;
		end else if (ls_need && !ls_req_q) begin
			ls_req_q <= 1'b1;
			ls_cmd_q <= ls_next;
		end
	end
	// ----------------------------------------------------------------
	// Storage bus controller port
	// ----------------------------------------------------------------
	assign ms_take = ms_got_q & ((state_q == MCC_S_DFETCH) |
		(state_q == MCC_S_DSTORE) | (state_q == MCC_S_C_WAIT));
	assign ms_go = (((state_q == MCC_S_DFETCH) | (state_q == MCC_S_DSTORE)) &
		~ms_req_q & ~ms_got_q) | ((state_q == MCC_S_C_LD2) & ls_done);

	always_comb begin
		ms_next = '{we: 1'b0, addr: adr, data: data_q};
		if (state_q == MCC_S_DSTORE) begin
			ms_next.we = 1'b1;
		end
		if (state_q == MCC_S_C_LD2) begin
			ms_next.addr = ls_rdata[MCC_ADR_LSB +: MCC_ADR_W];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ms_req_q <= 1'b0;
			ms_got_q <= 1'b0;
			ms_chk_q <= 1'b0;
			ms_data_q <= 64'h0000_0000_0000_0000;
			ms_cmd_q <= '0;
		end else begin
			if (ms_req_q && ms_ack) begin
				ms_req_q <= 1'b0;
				ms_got_q <= 1'b1;
				ms_chk_q <= ms_chk;
				ms_data_q <= ms_rdata;
			end else if (ms_take) begin
				ms_got_q <= 1'b0;
			end
			if (ms_go) begin
				ms_req_q <= 1'b1;
				ms_cmd_q <= ms_next;
			end
		end
	end
	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= MCC_S_IDLE;
			ctl_q <= 64'h0000_0000_0000_0000;
			data_q <= 64'h0000_0000_0000_0000;
			keep_q <= 4'h0;
			mclk_q <= 1'b0;
			dstore_q <= 1'b0;
			chain_q <= 1'b0;
			pf_need_q <= 1'b0;
			chain_wr_q <= 1'b0;
			svc_taken_q <= 1'b0;
			err_set <= 1'b0;
		end else begin
			err_set <= 1'b0;
			if (!svc_s) begin
				svc_taken_q <= 1'b0;
			end
			unique case (state_q)
				MCC_S_IDLE: begin
					if (en_q && op_s && svc_s && !svc_taken_q) begin
						svc_taken_q <= 1'b1;
						state_q <= MCC_S_ARB;
					end
				end
				MCC_S_ARB: begin
					if (mch_gnt) begin
						state_q <= MCC_S_LD0;
					end
				end
				MCC_S_LD0: begin
					if (ls_done) begin
						ctl_q <= ls_rdata;
						mclk_q <= 1'b1;
						state_q <= MCC_S_LD1;
					end
				end
				MCC_S_LD1: begin
					if (ls_done) begin
						data_q <= ls_rdata;
						state_q <= MCC_S_EVAL;
					end
				end
				MCC_S_EVAL: begin
					if (cnt == 16'h0000) begin
						state_q <= MCC_S_ST1;
					end else if (wr) begin
						ctl_q[MCC_CNT_LSB +: MCC_CNT_W] <= cnt - 16'h0001;
						ctl_q[MCC_BC_LSB +: 3] <= bc + 3'h1;
						if (cd && !ctl_q[MCC_PF_BIT] &&
							(cnt - 16'h0001) < MCC_CNT_CHAIN_LIM) begin
							pf_need_q <= 1'b1;
							ctl_q[MCC_PF_BIT] <= 1'b1;
						end
						if (bc == MCC_BC_FULL) begin
							state_q <= MCC_S_DFETCH;
						end else begin
							state_q <= MCC_S_XFER;
						end
					end else begin
						data_q <= put_byte(data_q, bwd ? ~bc : bc, bus_s2_q);
						ctl_q[MCC_CNT_LSB +: MCC_CNT_W] <= cnt - 16'h0001;
						ctl_q[MCC_BC_LSB +: 3] <= bc + 3'h1;
						dstore_q <= (bc == MCC_BC_FULL) || (cnt == 16'h0001);
						chain_q <= (cnt == 16'h0001) && cd;
						state_q <= MCC_S_XFER;
					end
				end
				MCC_S_DFETCH: begin
					if (ms_take) begin
						if (ms_chk_q) begin
							err_set <= 1'b1;
							state_q <= MCC_S_END;
						end else begin
							data_q <= ms_data_q;
							ctl_q[MCC_ADR_LSB +: MCC_ADR_W] <= adr + MCC_ADR_STEP;
							state_q <= MCC_S_XFER;
						end
					end
				end
				MCC_S_XFER: begin
					if (svc_out && !svc_s) begin
						if (wr) begin
							state_q <= MCC_S_ST1;
						end else if (dstore_q) begin
							state_q <= MCC_S_DSTORE;
						end else begin
							state_q <= chain_q ? MCC_S_C_LD2 : MCC_S_ST1;
						end
					end
				end
				MCC_S_DSTORE: begin
					if (ms_take) begin
						dstore_q <= 1'b0;
						if (ms_chk_q) begin
							err_set <= 1'b1;
							state_q <= MCC_S_END;
						end else begin
							ctl_q[MCC_ADR_LSB +: MCC_ADR_W] <= bwd ?
								adr - MCC_ADR_STEP : adr + MCC_ADR_STEP;
							state_q <= chain_q ? MCC_S_C_LD2 : MCC_S_ST1;
						end
					end
				end
				MCC_S_ST1: begin
					if (ls_done) begin
						state_q <= MCC_S_ST0;
					end
				end
				MCC_S_ST0: begin
					if (ls_done) begin
						state_q <= pf_need_q ? MCC_S_C_LD2 : MCC_S_END;
					end
				end
				MCC_S_C_LD2: begin
					if (ls_done) begin
						keep_q <= {ctl_q[MCC_OP_LSB +: 2], ctl_q[MCC_PCI_BIT],
							ctl_q[MCC_DCHK_BIT]};
						chain_wr_q <= wr;
						pf_need_q <= 1'b0;
						ctl_q <= ls_rdata;
						ctl_q[MCC_RES_LSB +: MCC_ADR_W] <=
							ls_rdata[MCC_ADR_LSB +: MCC_ADR_W];
						ctl_q[MCC_ADR_LSB +: MCC_ADR_W] <=
							ls_rdata[MCC_ADR_LSB +: MCC_ADR_W] + MCC_ADR_STEP;
						state_q <= wr ? MCC_S_C_ST2 : MCC_S_C_ST1;
					end
				end
				MCC_S_C_ST1: begin
					if (ls_done) begin
						state_q <= MCC_S_C_ST2;
					end
				end
				MCC_S_C_ST2: begin
					if (ls_done) begin
						mclk_q <= 1'b0;
						state_q <= MCC_S_C_WAIT;
					end
				end
				MCC_S_C_WAIT: begin
					if (ms_take) begin
						if (ms_chk_q) begin
							err_set <= 1'b1;
							state_q <= MCC_S_END;
						end else begin
							mclk_q <= 1'b1;
							ctl_q <= ms_data_q;
							ctl_q[MCC_OP_LSB +: 2] <= keep_q[3:2];
							ctl_q[MCC_PCI_BIT] <= keep_q[1];
							ctl_q[MCC_DCHK_BIT] <= keep_q[0];
							ctl_q[MCC_BC_LSB +: 3] <= dab_fix;
							ctl_q[MCC_DAB_LSB +: 3] <= dab_fix;
							state_q <= MCC_S_C_STN;
						end
					end
				end
				MCC_S_C_STN: begin
					if (ls_done) begin
						state_q <= MCC_S_END;
					end
				end
				MCC_S_END: begin
					if (!ls_ack) begin
						mclk_q <= 1'b0;
						chain_q <= 1'b0;
						chain_wr_q <= 1'b0;
						pf_need_q <= 1'b0;
						state_q <= MCC_S_IDLE;
					end
				end
			endcase
		end
	end
	// ----------------------------------------------------------------
	// Channel interface outputs
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_out <= 8'h00;
			svc_out <= 1'b0;
			cmd_out <= 1'b0;
		end else begin
			if (state_q == MCC_S_EVAL && wr && cnt != 16'h0000 &&
				bc != MCC_BC_FULL) begin
				bus_out <= get_byte(data_q, bc + 3'h1);
			end else if (state_q == MCC_S_DFETCH && ms_take) begin
				bus_out <= get_byte(ms_data_q, 3'h0);
			end
			if (!svc_s) begin
				svc_out <= 1'b0;
			end else if (state_q == MCC_S_XFER && !svc_out) begin
				svc_out <= 1'b1;
			end
			if (!svc_s) begin
				cmd_out <= 1'b0;
			end else if (state_q == MCC_S_EVAL && cnt == 16'h0000) begin
				cmd_out <= 1'b1;
			end
		end
	end
	// Read chaining never reaches the stop path; a chained write still stops at count zero
	assign mch_req = (state_q == MCC_S_ARB);
	assign end_pulse = (state_q == MCC_S_END) & ~ls_ack;
	assign mclk_run = mclk_q;
	assign ls_req = ls_req_q;
	assign ls_cmd = ls_cmd_q;
	assign ms_req = ms_req_q;
	assign ms_cmd = ms_cmd_q;
	// ----------------------------------------------------------------
	// APB registers
	// ----------------------------------------------------------------
	logic apb_wr, apb_setup;
	logic [31:0] stat;
	assign apb_setup = psel & ~penable;
	assign apb_wr = psel & penable & pwrite;
	assign pready = 1'b1;
	assign stat = {20'h0_0000, state_q, 1'b0, ctl_q[MCC_PCI_BIT],
		ctl_q[MCC_SLI_BIT], ctl_q[MCC_CC_BIT], chain_q | chain_wr_q,
		err_q, mclk_q, state_q != MCC_S_IDLE};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_q <= MCC_CTRL_EN_RST;
			err_q <= 1'b0;
			bytes_q <= 32'h0000_0000;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			if (apb_wr && paddr == MCC_CTRL_OFS) begin
				en_q <= pwdata[MCC_CTRL_EN_BIT];
			end
			if (err_set) begin
				err_q <= 1'b1;
			end else if (apb_wr && paddr == MCC_CTRL_OFS &&
				pwdata[MCC_CTRL_ERRCLR_BIT]) begin
				err_q <= 1'b0;
			end
			if (state_q == MCC_S_XFER && svc_out && !svc_s) begin
				bytes_q <= bytes_q + 32'h0000_0001;
			end
			if (apb_setup) begin
				pslverr <= 1'b0;
				unique case (paddr)
					MCC_CTRL_OFS: prdata <= {31'h0000_0000, en_q};
					MCC_STAT_OFS: prdata <= stat;
					MCC_BYTES_OFS: prdata <= bytes_q;
					default: begin
						prdata <= 32'h0000_0000;
						pslverr <= 1'b1;
					end
				endcase
			end
		end
	end
endmodule
`default_nettype wire

/* File: tb/mcc_seq_asserts.sv */
// Port-level checks of the multiplex chaining and write sequencer.
// Assumes it is bound onto every mcc_seq instance.
`timescale 1ns/100ps
`default_nettype none
module mcc_seq_asserts
	import mcc_pkg::*;
#(
	parameter int UA_W = 8
) (
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset, low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB write
	input wire logic [11:0] paddr, // APB address
	input wire logic [31:0] pwdata, // APB write data
	input wire logic [31:0] prdata, // APB read data
	input wire logic pready, // APB ready
	input wire logic pslverr, // APB error
	input wire logic op_in, // Operational in
	input wire logic svc_in, // Service in
	input wire logic [7:0] bus_in, // Bus in
	input wire logic [7:0] bus_out, // Bus out
	input wire logic svc_out, // Service out
	input wire logic cmd_out, // Command out
	input wire logic [UA_W-1:0] unit_addr, // Unit address
	input wire logic mch_req, // Priority request
	input wire logic mch_gnt, // Priority grant
	input wire logic mclk_run, // Clock running
	input wire logic end_pulse, // Ending
	input wire logic ms_req, // Storage request
	input wire mcc_msreq_t ms_cmd, // Storage command
	input wire logic ms_ack, // Storage ack
	input wire logic ms_chk, // Storage check
	input wire logic [63:0] ms_rdata, // Storage data
	input wire logic ls_req, // Local request
	input wire mcc_lsreq_t ls_cmd, // Local command
	input wire logic ls_ack, // Local ack
	input wire logic [63:0] ls_rdata // Local data
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ----------------------------------------------------------------
	// Sequences
	// ----------------------------------------------------------------
	sequence s_stop;
		$rose(cmd_out);
	endsequence
	sequence s_byte;
		$rose(svc_out);
	endsequence
	sequence s_ends;
		##[1:200] end_pulse;
	endsequence
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	AST_MS_HOLD: assert property (
		ms_req && !ms_ack |=> ms_req && $stable(ms_cmd))
		else $error("storage request changed before ack");
	AST_MS_REL: assert property (ms_ack |=> !ms_req)
		else $error("storage request kept after ack");
	AST_LS_UNIT: assert property (
		ls_req |-> ls_cmd.addr[9:2] == unit_addr)
		else $error("local storage outside unit block");
	AST_BUS_FIRST: assert property (s_byte |-> $stable(bus_out))
		else $error("service out rose with bus out changing");
	AST_NO_BOTH: assert property (!(svc_out && cmd_out))
		else $error("service out and command out together");
	AST_STOP_END: assert property (s_stop |-> s_ends)
		else $error("stop not followed by ending");
	AST_BYTE_END: assert property (s_byte |-> s_ends)
		else $error("byte cycle not followed by ending");
	AST_SVC_HOLD: assert property (svc_out && svc_in |=> svc_out)
		else $error("service out dropped under service in");
	AST_CMD_HOLD: assert property (cmd_out && svc_in |=> cmd_out)
		else $error("command out dropped under service in");
	AST_END_ONE: assert property (end_pulse |=> !end_pulse)
		else $error("ending longer than one cycle");
	AST_GNT: assert property (mch_req && mch_gnt |=> !mch_req)
		else $error("priority request kept after grant");
endmodule
bind mcc_seq mcc_seq_asserts #(.UA_W(UA_W)) mcc_seq_asserts_i (.*);
`default_nettype wire

/* File: tb/mcc_cu_model.sv */
// Control unit model on the parallel channel interface.
// Assumes go pulses only while the model is idle.
`timescale 1ns/100ps
`default_nettype none
module mcc_cu_model (
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset, low
	input wire logic go, // Ask one byte cycle
	input wire logic slow, // Answer late
	input wire logic [7:0] byte_in, // Byte offered
	input wire logic [7:0] bus_out, // Channel bus out
	input wire logic svc_out, // Service out
	input wire logic cmd_out, // Command out
	output logic op_in, // Operational in
	output logic svc_in, // Service in
	output logic [7:0] bus_in, // Bus in
	output logic got_stop, // Ended by stop
	output logic [7:0] got_byte // Byte taken
);
	logic [2:0] st_q;
	logic [2:0] dly_q;
	logic [7:0] byte_q;
	// Released bus shows the inverse of the last byte
	assign bus_in = svc_in ? byte_q : ~byte_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= 3'h0;
			dly_q <= 3'h0;
			byte_q <= 8'h00;
			op_in <= 1'b0;
			svc_in <= 1'b0;
			got_stop <= 1'b0;
			got_byte <= 8'h00;
		end else begin
			case (st_q)
			3'h0: if (go) begin
				op_in <= 1'b1;
				byte_q <= byte_in;
				st_q <= 3'h1;
			end
			3'h1: begin
				svc_in <= 1'b1;
				st_q <= 3'h2;
			end
			3'h2: if (svc_out || cmd_out) begin
				got_stop <= cmd_out;
				got_byte <= bus_out;
				dly_q <= slow ? 3'h6 : 3'h0;
				st_q <= 3'h3;
			end
			3'h3: if (dly_q != 3'h0) begin
				dly_q <= dly_q - 3'h1;
			end else begin
				svc_in <= 1'b0;
				op_in <= !got_stop;
				st_q <= 3'h4;
			end
			default: if (!svc_out && !cmd_out) begin
				st_q <= 3'h0;
			end
			endcase
		end
	end
endmodule
`default_nettype wire

/* File: tb/tb_mcc_seq.sv */
// Self-checking bench of the multiplex chaining and write sequencer.
// Assumes the control unit model and the bound checker.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
	err_total++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_mcc_seq
	import mcc_pkg::*;
;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata;
	logic pready, pslverr, op_in, svc_in, svc_out, cmd_out, mch_req;
	logic mch_gnt = 0, mclk_run, end_pulse, ms_req, ms_ack = 0, ms_chk = 0;
	logic ls_req, ls_ack = 0, go = 0, slow = 0, got_stop, mclk_d = 0;
	logic [7:0] bus_in, bus_out, byte_in = '0, got_byte;
	logic [7:0] unit_addr = 8'h05;
	logic [63:0] ms_rdata = '0, ls_rdata = '0;
	logic [63:0] lsm [0:1023];
	logic [23:0] ms_raddr = '0;
	mcc_msreq_t ms_cmd;
	mcc_lsreq_t ls_cmd;
	int err_total = 0, n_tests = 0, end_cnt = 0, ms_n = 0, cyc = 0;
	int clk_on = 0;
	mcc_seq mcc_seq_i (.*);
	mcc_cu_model mcc_cu_model_i (.*);
	always #2 pclk = ~pclk;
	// ----------------------------------------------------------------
	// Storage, priority and timeout models
	// ----------------------------------------------------------------
	function automatic logic [63:0] mdat(input logic [23:0] a);
		return {a ^ 24'h5D_0005, 8'hA5, a, 8'h3C};
	endfunction
	always @(posedge pclk) begin
		ms_ack <= ms_req && !ms_ack;
		if (ms_req && !ms_ack) begin
			ms_rdata <= mdat(ms_cmd.addr);
			ms_n <= ms_n + 1;
			if (!ms_cmd.we) ms_raddr <= ms_cmd.addr;
		end
		mclk_d <= mclk_run;
		clk_on <= clk_on + int'(mclk_run & !mclk_d);
		ls_ack <= ls_req && !ls_ack;
		if (ls_req && !ls_ack) begin
			ls_rdata <= lsm[ls_cmd.addr];
			if (ls_cmd.we) lsm[ls_cmd.addr] <= ls_cmd.data;
		end
		mch_gnt <= mch_req && !mch_gnt;
		end_cnt <= end_cnt + int'(end_pulse);
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			results();
		end
	end
	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	function automatic logic [63:0] w0(input logic [1:0] op,
		input logic [23:0] ad, input logic [2:0] bc, input logic [15:0] n,
		input logic cd);
		logic [63:0] w;
		w = '0;
		w[MCC_OP_LSB+:2] = op;
		w[MCC_ADR_LSB+:24] = ad;
		w[MCC_CD_BIT] = cd;
		w[MCC_BC_LSB+:3] = bc;
		w[MCC_CNT_LSB+:16] = n;
		return w;
	endfunction
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] wd, output logic [31:0] d, output logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		d = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic run(input logic [63:0] a0, a1, a2, input logic [7:0] b,
		input logic sl);
		int n;
		lsm[{unit_addr, MCC_W0}] = a0;
		lsm[{unit_addr, MCC_W1}] = a1;
		lsm[{unit_addr, MCC_W2}] = a2;
		n = end_cnt;
		byte_in <= b;
		slow <= sl;
		go <= 1'b1;
		@(posedge pclk);
		go <= 1'b0;
		while (end_cnt == n) @(posedge pclk);
		while (ms_req || ls_req) @(posedge pclk);
		@(posedge pclk);
	endtask
	task automatic results();
		if (err_total == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_regs();
		logic [31:0] d;
		logic e;
		apb(1'b0, MCC_CTRL_OFS, 32'h0000_0000, d, e);
		`CHK("ctrl reset", 32'h0000_0000, d)
		apb(1'b0, 12'h00C, 32'h0000_0000, d, e);
		`CHK("unmapped error", 1'b1, e)
		apb(1'b1, MCC_CTRL_OFS, 32'h0000_0001, d, e);
		apb(1'b0, MCC_CTRL_OFS, 32'h0000_0000, d, e);
		`CHK("ctrl enable", 32'h0000_0001, d)
	endtask
	task automatic t_wfetch();
		int m;
		m = ms_n;
		run(w0(2'h1, 24'h12_3450, 3'h7, 16'h0003, 0), '0, '0, 8'h00, 0);
		`CHK("fetch count", m + 1, ms_n)
		`CHK("fetch addr", 24'h12_3450, ms_raddr)
		`CHK("byte out", 8'h4F, got_byte)
		`CHK("word1", mdat(24'h12_3450), lsm[{unit_addr, MCC_W1}])
		`CHK("word0", w0(2'h1, 24'h12_3458, 3'h0, 16'h0002, 0),
			lsm[{unit_addr, MCC_W0}])
	endtask
	task automatic t_wbyte();
		int m;
		for (int i = 0; i < 2; i++) begin
			m = ms_n;
			run(w0({i[0], 1'b1}, 24'h00_200A, 3'h2, 16'h0005, 0),
				64'h0011_2233_4455_6677, '0, 8'h00, 1);
			`CHK("byte out", 8'h33, got_byte)
			`CHK("no fetch", m, ms_n)
			`CHK("word0", w0({i[0], 1'b1}, 24'h00_200A, 3'h3, 16'h0004, 0),
				lsm[{unit_addr, MCC_W0}])
		end
	endtask
	task automatic t_chain();
		logic [63:0] nw;
		logic [1:0] op;
		logic [2:0] bc;
		int m;
		for (int i = 0; i < 2; i++) begin
			op = i ? MCC_OP_RBWD : MCC_OP_READ;
			bc = i ? 3'h2 : 3'h5;
			m = clk_on;
			run(w0(op, 24'h00_4000, {3{i[0]}}, 16'h0001, 1) |
				64'h0000_0000_0808_0000, '0, 64'h0000_8000_0000_0000,
				8'hC7, 0);
			nw = lsm[{unit_addr, MCC_W0}];
			`CHK("ccw addr", 24'h00_8000, ms_raddr)
			`CHK("no stop", 1'b0, got_stop)
			`CHK("clock restart", m + 2, clk_on)
			`CHK("word1", 8'hC7, lsm[{unit_addr, MCC_W1}][63:56])
			`CHK("residual", 24'h00_8000, lsm[{unit_addr, MCC_W2}][23:0])
			`CHK("cmd addr", 24'h00_8008, lsm[{unit_addr, MCC_W2}][55:32])
			`CHK("op kept", op, nw[MCC_OP_LSB+:2])
			`CHK("flags kept", 2'b11, {nw[MCC_PCI_BIT], nw[MCC_DCHK_BIT]})
			`CHK("byte count", bc, nw[MCC_BC_LSB+:3])
			`CHK("offset", bc, nw[MCC_DAB_LSB+:3])
		end
	endtask
	task automatic t_wchain();
		run(w0(2'h1, 24'h00_200A, 3'h2, 16'h0005, 1), '0,
			64'h0000_8000_0000_0000, 8'h00, 0);
		`CHK("pf word0", w0(2'h1, 24'h00_200A, 3'h3, 16'h0004, 1) |
			64'h0100_0000, lsm[{unit_addr, MCC_W0}])
		`CHK("pf ccw addr", 24'h00_8000, ms_raddr)
		`CHK("pf w2", 24'h00_8008, lsm[{unit_addr, MCC_W2}][55:32])
	endtask
	task automatic t_wzero();
		logic [63:0] a0;
		a0 = w0(2'h1, 24'h00_3000, 3'h1, 16'h0000, 0);
		run(a0, 64'h0123_4567_89AB_CDEF, '0, 8'h00, 0);
		`CHK("stop", 1'b1, got_stop)
		`CHK("word0", a0, lsm[{unit_addr, MCC_W0}])
		`CHK("word1", 64'h0123_4567_89AB_CDEF, lsm[{unit_addr, MCC_W1}])
	endtask
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_wfetch();
		t_wbyte();
		t_chain();
		t_wchain();
		t_wzero();
		results();
	end
endmodule
`default_nettype wire
